// [rtl/mmpc_pkg.sv]
// Purpose: Shared constants and types for the memory map and paging controller.
// Assumes: One 25 MHz system clock, 16-bit local addresses, 18-bit global addresses.
// Notes:   Register byte addresses are four times the printed register index.
package mmpc_pkg;

  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned GADDR_W       = 18;
  localparam int unsigned DATA_W        = 8;

  // Register indices and derived byte addresses.
  localparam logic [7:0]  IDX_PAGE      = 8'h15;
  localparam logic [7:0]  IDX_DIRECT    = 8'h11;
  localparam logic [7:0]  IDX_MODE      = 8'h0b;
  localparam logic [7:0]  IDX_SECURITY  = 8'h12;
  localparam logic [11:0] AXI_PAGE      = {2'h0, IDX_PAGE, 2'h0};
  localparam logic [11:0] AXI_DIRECT    = {2'h0, IDX_DIRECT, 2'h0};
  localparam logic [11:0] AXI_MODE      = {2'h0, IDX_MODE, 2'h0};
  localparam logic [11:0] AXI_SECURITY  = {2'h0, IDX_SECURITY, 2'h0};

  localparam logic [7:0]  PAGE_RST      = 8'h0e;
  localparam logic [3:0]  PAGE_SEL_RST  = 4'he;
  localparam logic [7:0]  DIRECT_RST    = 8'h00;

  // Local map windows.
  localparam logic [15:0] REG_LO        = 16'h0000;
  localparam logic [15:0] REG_HI        = 16'h03ff;
  localparam logic [15:0] RAM_LO        = 16'h3800;
  localparam logic [15:0] RAM_HI        = 16'h3fff;
  localparam logic [15:0] FIX_LO        = 16'h4000;
  localparam logic [15:0] FIX_HI        = 16'h7fff;
  localparam logic [15:0] WIN_LO        = 16'h8000;
  localparam logic [15:0] WIN_HI        = 16'hbfff;
  localparam logic [15:0] TOP_LO        = 16'hc000;
  localparam logic [15:0] DBG_LO        = 16'hff00;
  localparam logic [3:0]  FIX_PAGE      = 4'hd;
  localparam logic [3:0]  TOP_PAGE      = 4'hf;
  localparam int unsigned PAGE_OFS_W    = 14;

  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_REGS,
    TGT_RAM,
    TGT_FLASH,
    TGT_DEBUG
  } mmpc_tgt_t;

  typedef struct packed {
    logic                 req;
    logic                 wr;
    logic [ADDR_W-1:0]    addr;
    logic [DATA_W-1:0]    wdata;
  } mmpc_req_t;

  typedef struct packed {
    logic                 req;
    logic                 wr;
    logic                 from_dbg;
    mmpc_tgt_t            tgt;
    logic [GADDR_W-1:0]   gaddr;
    logic [DATA_W-1:0]    wdata;
  } mmpc_gbus_t;

endpackage : mmpc_pkg

// [rtl/mmpc_top.sv]
// Purpose: Memory map and paging controller between processor and debug masters and on-chip resources.
// Assumes: Both masters present one access request per cycle and hold it until granted.
// Notes:   Software reaches the control registers over AXI4-Lite; byte address is four times the index.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns

// How it works
// - The four page select bits pick the 16 kB flash block seen at local 0x8000 to 0xBFFF for both masters.
// - Paging lets 16-bit local masters reach the whole 256 kByte global space through 18-bit global addresses.
// - Simultaneous requests are arbitrated with the debug master first and every local address is decoded.
// - Each master has its own map, with the debug firmware window visible only to the debug master.
// - A processor access to an unmapped address in either mode raises a system reset request.
// - Only normal and special single-chip modes exist, and special mode forces debug entry after each reset.
// - On a secured device the debug master may not reach flash and processor flash writes are blocked.
// - The processor has a dedicated port to read and update the page register during paged call and return.
// - A paged call or return update lands in the page register at the next edge, before the instruction ends.
// - The direct page register takes only the first write and gives the upper byte of the direct range.
// - The mode select input is captured at reset release, 1 meaning normal and 0 special single-chip mode.
module mmpc_top
  import mmpc_pkg::*;
(
  // Clock and reset
  input  wire logic                 SYS_CLK_I,
  input  wire logic                 RST_N_I,
  // Mode strap and security state
  input  wire logic                 MODE_SEL_I,
  input  wire logic                 SECURED_I,
  // Processor master
  input  wire mmpc_req_t            CPU_REQ_I,
  output logic                      CPU_GNT_O,
  // Debug master
  input  wire mmpc_req_t            DBG_REQ_I,
  output logic                      DBG_GNT_O,
  // Paged call and return port
  input  wire logic                 CPU_PAGE_WE_I,
  input  wire logic [DATA_W-1:0]    CPU_PAGE_WDATA_I,
  output logic [DATA_W-1:0]         CPU_PAGE_RDATA_O,
  // Global bus toward resources
  output mmpc_gbus_t                GBUS_O,
  output logic [DATA_W-1:0]         DIRECT_PAGE_O,
  // System status
  output logic                      NORMAL_SINGLE_CHIP_O,
  output logic                      DEBUG_ENTRY_O,
  output logic                      SYS_RESET_REQ_O,
  // AXI4-Lite slave
  input  wire logic [11:0]          S_AXI_AWADDR,
  input  wire logic                 S_AXI_AWVALID,
  output logic                      S_AXI_AWREADY,
  input  wire logic [31:0]          S_AXI_WDATA,
  input  wire logic [3:0]           S_AXI_WSTRB,
  input  wire logic                 S_AXI_WVALID,
  output logic                      S_AXI_WREADY,
  output logic [1:0]                S_AXI_BRESP,
  output logic                      S_AXI_BVALID,
  input  wire logic                 S_AXI_BREADY,
  input  wire logic [11:0]          S_AXI_ARADDR,
  input  wire logic                 S_AXI_ARVALID,
  output logic                      S_AXI_ARREADY,
  output logic [31:0]               S_AXI_RDATA,
  output logic [1:0]                S_AXI_RRESP,
  output logic                      S_AXI_RVALID,
  input  wire logic                 S_AXI_RREADY
);

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Local decode; the debug map adds its firmware window on top of the shared one.
  function automatic mmpc_tgt_t decode(input logic [15:0] a, input logic dbg);
    if (dbg && (a >= DBG_LO))
      decode = TGT_DEBUG;
    else if (in_range(a, REG_LO, REG_HI))
      decode = TGT_REGS;
    else if (in_range(a, RAM_LO, RAM_HI))
      decode = TGT_RAM;
    else if (a >= FIX_LO)
      decode = TGT_FLASH;
    else
      decode = TGT_NONE;
  endfunction

  // Global address formation from page and local offset.
  function automatic logic [GADDR_W-1:0] to_global(input logic [15:0] a, input logic [3:0] pg);
    logic [3:0] blk;
    blk = pg;
    if (in_range(a, FIX_LO, FIX_HI))
      blk = FIX_PAGE;
    else if (a >= TOP_LO)
      blk = TOP_PAGE;
    to_global = {blk, a[PAGE_OFS_W-1:0]};
  endfunction

  // Only the four page select bits are stored; the upper bits always read zero.
  function automatic logic [DATA_W-1:0] page_value(input logic [DATA_W-1:0] v);
    page_value = {4'h0, v[3:0]};
  endfunction

  // Registers are whole words, so the byte lane bits of an address are ignored.
  function automatic logic [11:0] word_addr(input logic [11:0] a);
    word_addr = {a[11:2], 2'b00};
  endfunction

  // Writes to a known read-only register are still answered OKAY and simply change nothing.
  function automatic logic known_reg(input logic [11:0] a);
    known_reg = (a == AXI_PAGE) || (a == AXI_DIRECT) || (a == AXI_MODE) || (a == AXI_SECURITY);
  endfunction

  logic [DATA_W-1:0] page_r;
  logic [DATA_W-1:0] direct_r;
  logic              direct_done_r;
  logic              mode_latch_r;
  logic              rst_seen_r;
  logic              dbg_entry_r;
  logic              sys_rst_r;
  mmpc_gbus_t        gbus_r;

  // Arbitration: debug first since its accesses steal single cycles.
  // A debug master that never drops its request would starve the processor, so it must only steal cycles.
  logic              dbg_sel;
  logic              cpu_sel;
  mmpc_req_t         win;
  mmpc_tgt_t         win_tgt;
  logic              blocked;
  assign dbg_sel   = DBG_REQ_I.req;
  assign cpu_sel   = CPU_REQ_I.req && !DBG_REQ_I.req;
  assign win       = dbg_sel ? DBG_REQ_I : CPU_REQ_I;
  assign win_tgt   = decode(win.addr, dbg_sel);
  assign blocked   = SECURED_I && (win_tgt == TGT_FLASH) && (dbg_sel || win.wr);
  assign DBG_GNT_O = dbg_sel;
  assign CPU_GNT_O = cpu_sel;

  // A blocked or unmapped access keeps the request low so that no resource ever sees it.
  mmpc_gbus_t        gbus_nxt;

  always_comb
  begin
    gbus_nxt          = '0;
    gbus_nxt.req      = win.req && !blocked && (win_tgt != TGT_NONE);
    gbus_nxt.wr       = win.wr;
    gbus_nxt.from_dbg = dbg_sel;
    gbus_nxt.tgt      = blocked ? TGT_NONE : win_tgt;
    gbus_nxt.gaddr    = to_global(win.addr, page_r[3:0]);
    gbus_nxt.wdata    = win.wdata;
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      gbus_r <= '0;
    else
      gbus_r <= gbus_nxt;
  end

  // Unmapped processor access resets the system in both modes.
  // The request is a one-cycle pulse per access; the reset generator is expected to stretch it.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      sys_rst_r <= 1'b0;
    else
      sys_rst_r <= cpu_sel && (win_tgt == TGT_NONE);
  end

  // Mode strap is caught in the first clocked cycle after release, not by the reset itself.
  // A strap that changes later has no effect until the next reset.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rst_seen_r   <= 1'b0;
      mode_latch_r <= 1'b1;
      dbg_entry_r  <= 1'b0;
    end
    else if (!rst_seen_r)
    begin
      rst_seen_r   <= 1'b1;
      mode_latch_r <= MODE_SEL_I;
      dbg_entry_r  <= !MODE_SEL_I;
    end
    else
      dbg_entry_r  <= 1'b0;
  end

  // AXI4-Lite write path: address and data accepted in either order.
  logic        aw_got_r;
  logic        w_got_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        do_wr;
  logic        page_hit;
  logic        direct_hit;
  logic        wr_known;
  logic        aw_take;
  logic        w_take;
  logic        b_done;

  assign S_AXI_AWREADY = !aw_got_r && !bvalid_r;
  assign S_AXI_WREADY  = !w_got_r && !bvalid_r;
  assign aw_take       = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_take        = S_AXI_WVALID && S_AXI_WREADY;
  assign b_done        = bvalid_r && S_AXI_BREADY;
  assign do_wr         = aw_got_r && w_got_r && !bvalid_r;
  // A bus page write that meets a paged port update in the same cycle is lost, by design.
  assign page_hit      = do_wr && (aw_addr_r == AXI_PAGE) && w_strb_r[0];
  assign direct_hit    = do_wr && (aw_addr_r == AXI_DIRECT) && w_strb_r[0];
  assign wr_known      = known_reg(aw_addr_r);

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= word_addr(S_AXI_AWADDR);
      end
      if (w_take)
      begin
        w_got_r  <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end
      if (do_wr)
      begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (b_done)
        bvalid_r <= 1'b0;
    end
  end

  // The paged call and return port beats a bus write in the same cycle since the instruction cannot stall.
  logic [DATA_W-1:0] page_nxt;

  always_comb
  begin
    page_nxt = page_r;
    if (CPU_PAGE_WE_I)
      page_nxt = page_value(CPU_PAGE_WDATA_I);
    else if (page_hit)
      page_nxt = page_value(w_data_r[7:0]);
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      page_r <= PAGE_RST;
    else
      page_r <= page_nxt;
  end

  // Write-once direct page; later writes are acknowledged but dropped.
  // The direct range itself is formed by the processor; this block only holds the page byte.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      direct_r      <= DIRECT_RST;
      direct_done_r <= 1'b0;
    end
    else if (direct_hit && !direct_done_r)
    begin
      direct_r      <= w_data_r[7:0];
      direct_done_r <= 1'b1;
    end
  end

  // AXI4-Lite read path: one cycle from address acceptance to data.
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [11:0] ra;
  logic        ar_take;
  logic        r_done;
  logic [31:0] rdata_nxt;
  logic [1:0]  rresp_nxt;
  assign ra            = word_addr(S_AXI_ARADDR);
  assign S_AXI_ARREADY = !rvalid_r;
  assign ar_take       = S_AXI_ARVALID && S_AXI_ARREADY;
  assign r_done        = rvalid_r && S_AXI_RREADY;

  // The security bit is read live, so a read shows the state at the edge where its address is taken.
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    rresp_nxt = RESP_OKAY;
    unique case (ra)
      AXI_PAGE:     rdata_nxt = {24'h000000, page_r};
      AXI_DIRECT:   rdata_nxt = {24'h000000, direct_r};
      AXI_MODE:     rdata_nxt = {30'h0, direct_done_r, mode_latch_r};
      AXI_SECURITY: rdata_nxt = {31'h0, SECURED_I};
      default:      rresp_nxt = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
    end
    else if (r_done)
      rvalid_r <= 1'b0;
  end

  assign S_AXI_BVALID         = bvalid_r;
  assign S_AXI_BRESP          = bresp_r;
  assign S_AXI_RVALID         = rvalid_r;
  assign S_AXI_RDATA          = rdata_r;
  assign S_AXI_RRESP          = rresp_r;
  assign GBUS_O               = gbus_r;
  assign DIRECT_PAGE_O        = direct_r;
  assign CPU_PAGE_RDATA_O     = page_r;
  assign NORMAL_SINGLE_CHIP_O = mode_latch_r;
  assign DEBUG_ENTRY_O        = dbg_entry_r;
  assign SYS_RESET_REQ_O      = sys_rst_r;

endmodule // mmpc_top

// [test/mmpc_mstr_model.sv]
// Purpose: Behavioural bus master for the processor or the debug unit.
// Assumes: One access at a time, launched by a one-cycle go strobe.
// Notes:   A released request shows the inverted payload so stale values never match by chance.
`timescale 1ns/1ns
module mmpc_mstr_model
  import mmpc_pkg::*;
(
  // Bench control
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire mmpc_req_t  cmd_i,
  // Grant handshake
  input  wire logic       gnt_i,
  output mmpc_req_t       req_o
);
  initial req_o = '0;
  always @(posedge clk_i)
  begin
    if (go_i)
      req_o <= cmd_i;
    else if (req_o.req && gnt_i)
      req_o <= {1'b0, ~req_o.wr, ~req_o.addr, ~req_o.wdata};
  end
endmodule // mmpc_mstr_model

// [test/mmpc_top_asserts.sv]
// Purpose: Port-level assertions for the memory map and paging controller.
// Assumes: One clock domain and an asynchronous active-low reset.
// Notes:   Bound into the top module by the statement at the foot.
`timescale 1ns/1ns
module mmpc_top_chk
  import mmpc_pkg::*;
(
  // Clock and state
  input wire logic        SYS_CLK_I,
  input wire logic        RST_N_I,
  input wire logic        SECURED_I,
  input wire logic        S_AXI_WVALID,
  // Masters
  input wire mmpc_req_t   CPU_REQ_I,
  input wire mmpc_req_t   DBG_REQ_I,
  input wire logic        CPU_GNT_O,
  input wire logic        DBG_GNT_O,
  input wire logic        CPU_PAGE_WE_I,
  input wire logic [7:0]  CPU_PAGE_WDATA_I,
  input wire logic [7:0]  CPU_PAGE_RDATA_O,
  // Results
  input wire mmpc_gbus_t  GBUS_O,
  input wire logic        SYS_RESET_REQ_O,
  input wire logic        DEBUG_ENTRY_O,
  input wire logic        NORMAL_SINGLE_CHIP_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic [15:0] ca;
  logic [15:0] da;
  logic [13:0] co;
  logic [3:0]  pw;
  assign ca = CPU_REQ_I.addr;
  assign da = DBG_REQ_I.addr;
  assign co = ca[13:0];
  assign pw = CPU_PAGE_WDATA_I[3:0];
  a_dbg_first: assert property (DBG_REQ_I.req |-> DBG_GNT_O && !CPU_GNT_O)
    else $error("debug request not served first");
  a_win_addr: assert property (CPU_GNT_O && ca[15:14] == 2'b10 && !SECURED_I && !CPU_PAGE_WE_I && !S_AXI_WVALID
    |=> GBUS_O.tgt == TGT_FLASH && GBUS_O.gaddr == {$past(CPU_PAGE_RDATA_O[3:0]), $past(co)})
    else $error("window address wrong");
  a_fix_page: assert property (CPU_GNT_O && ca[15:14] == 2'b01 && !SECURED_I |=> GBUS_O.gaddr[17:14] == FIX_PAGE)
    else $error("fixed page wrong");
  a_unmapped: assert property (CPU_GNT_O && ca inside {[16'h0400:16'h37ff]} |=> SYS_RESET_REQ_O && !GBUS_O.req)
    else $error("no reset on unmapped access");
  a_dbg_window: assert property (DBG_GNT_O && da >= DBG_LO |=> GBUS_O.from_dbg && GBUS_O.tgt == TGT_DEBUG)
    else $error("debug window not decoded");
  a_sec_block: assert property (DBG_GNT_O && SECURED_I && da inside {[16'h4000:16'hfeff]} |=> !GBUS_O.req)
    else $error("secured flash access passed");
  a_page_port: assert property (CPU_PAGE_WE_I |=> CPU_PAGE_RDATA_O == {4'h0, $past(pw)})
    else $error("paged port update missing");
  a_entry_pulse: assert property (DEBUG_ENTRY_O |-> !NORMAL_SINGLE_CHIP_O ##1 !DEBUG_ENTRY_O)
    else $error("debug entry pulse wrong");
  c_both: cover property (DBG_REQ_I.req && CPU_REQ_I.req);
  c_rst: cover property (SYS_RESET_REQ_O);
  c_entry: cover property (DEBUG_ENTRY_O);
endmodule // mmpc_top_chk

bind mmpc_top mmpc_top_chk u_chk (.SYS_CLK_I, .RST_N_I, .SECURED_I, .S_AXI_WVALID, .CPU_REQ_I, .DBG_REQ_I,
  .CPU_GNT_O, .DBG_GNT_O, .CPU_PAGE_WE_I, .CPU_PAGE_WDATA_I, .CPU_PAGE_RDATA_O, .GBUS_O, .SYS_RESET_REQ_O,
  .DEBUG_ENTRY_O, .NORMAL_SINGLE_CHIP_O);

// [test/test_memory_map_paging_control.sv]
// Purpose: Self-checking bench for the memory map and paging controller.
// Assumes: Master models hold requests until granted; AXI4-Lite tasks below.
// Notes:   Expected bus results are queued and matched by a monitor.
`timescale 1ns/1ns
module test_memory_map_paging_control
  import mmpc_pkg::*;
;
  logic clk, rst_n, mode, sec, cgo, dgo, pwe, cgnt, dgnt, nsc, dent, srst;
  logic awv, wv, bv, bready, arv, rv, rready, awr, wrdy, arr;
  logic [7:0] pwd, prd, dpo;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd;
  logic [1:0] br, rr;
  logic [3:0] p, ws;
  logic [13:0] o;
  logic [32:0] me, mm;
  logic [32:0] expq[$];
  mmpc_req_t ccmd, dcmd, creq, dreq;
  mmpc_gbus_t gbus;
  int err_count, cmp_count;
  mmpc_top u_dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .MODE_SEL_I(mode), .SECURED_I(sec), .CPU_REQ_I(creq),
    .CPU_GNT_O(cgnt), .DBG_REQ_I(dreq), .DBG_GNT_O(dgnt), .CPU_PAGE_WE_I(pwe), .CPU_PAGE_WDATA_I(pwd),
    .CPU_PAGE_RDATA_O(prd), .GBUS_O(gbus), .DIRECT_PAGE_O(dpo), .NORMAL_SINGLE_CHIP_O(nsc),
    .DEBUG_ENTRY_O(dent), .SYS_RESET_REQ_O(srst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready));
  mmpc_mstr_model u_cpu (.clk_i(clk), .go_i(cgo), .cmd_i(ccmd), .gnt_i(cgnt), .req_o(creq));
  mmpc_mstr_model u_dbg (.clk_i(clk), .go_i(dgo), .cmd_i(dcmd), .gnt_i(dgnt), .req_o(dreq));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors=%0d compares=%0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function automatic logic [32:0] ex(input logic rs, input logic w, input logic db, input mmpc_tgt_t t,
                                     input logic [17:0] g);
    return {rs, !rs, w, db, t, g, 8'h5a};
  endfunction
  // Write when w is set, else read; e holds the expected response and read data.
  task automatic axi(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [33:0] e);
    logic ta, tw, tr;
    logic [33:0] r;
    int n;
    n = 0;
    tr = 0;
    awa <= a;
    ara <= a;
    wd <= {24'h0, d};
    {awv, wv, bready, arv, rready} <= {w, w, w, !w, !w};
    while (!tr && n < 64)
    begin
      @(negedge clk);
      ta = awv && awr || arv && arr;
      tw = wv && wrdy;
      tr = bready && bv || rready && rv;
      r = w ? {br, 32'h0} : {rr, rd};
      @(posedge clk);
      {awv, arv, wv} <= {awv && !ta, arv && !ta, wv && !tw};
      {bready, rready} <= {bready && !tr, rready && !tr};
      n++;
    end
    if (!tr)
    begin
      err_count++;
      wrap_up;
    end
    chk(w ? r[33:32] : r, w ? e[33:32] : e);
    @(posedge clk);
  endtask
  task automatic acc(input logic [1:0] who, input logic w, input logic [15:0] a, input logic [32:0] ed, ec);
    int n;
    if (who[1] && ed[32:31] != 0)
      expq.push_back(ed);
    if (who[0] && ec[32:31] != 0)
      expq.push_back(ec);
    ccmd <= {1'b1, w, a, 8'h5a};
    dcmd <= {1'b1, w, a, 8'h5a};
    {dgo, cgo} <= who;
    @(posedge clk);
    {dgo, cgo} <= 2'b00;
    n = 0;
    do
      @(negedge clk);
    while ((creq.req || dreq.req) && n++ < 64);
    if (n >= 64)
    begin
      err_count++;
      wrap_up;
    end
    @(posedge clk);
  endtask
  // Flash results compare the global address; reset results only the reset and request flags; others target and flags.
  always @(posedge clk)
  begin
    if (rst_n && (gbus.req || srst))
    begin
      me = expq.size() > 0 ? expq.pop_front() : '0;
      mm = me[32] ? 33'h1_8000_0000 : (me[28:26] == TGT_FLASH ? 33'h1_ffff_ff00 : 33'h1_fc00_0000);
      chk({srst, gbus} & mm, me & mm);
    end
  end
  initial
  begin
    {rst_n, sec, cgo, dgo, pwe, pwd, awa, ara, wd} = '0;
    {awv, wv, bready, arv, rready, ccmd, dcmd} = '0;
    mode = 1'b1;
    ws = 4'hf;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    void'($urandom(32'hd0041c71));
    repeat (2) @(posedge clk);
    chk({nsc, prd}, {1'b1, PAGE_RST});
    axi(0, AXI_PAGE, 8'h00, {RESP_OKAY, 24'h0, PAGE_RST});
    repeat (6)
    begin
      p = 4'($urandom);
      o = 14'($urandom);
      axi(1, AXI_PAGE, {4'h0, p}, 0);
      acc(2'b01, 1, {2'b10, o}, 0, ex(0, 1, 0, TGT_FLASH, {p, o}));
      acc(2'b11, 0, {2'b10, o}, ex(0, 0, 1, TGT_FLASH, {p, o}), ex(0, 0, 0, TGT_FLASH, {p, o}));
    end
    acc(2'b01, 0, {2'b01, o}, 0, ex(0, 0, 0, TGT_FLASH, {FIX_PAGE, o}));
    acc(2'b01, 0, 16'hff10, 0, ex(0, 0, 0, TGT_FLASH, {TOP_PAGE, 14'h3f10}));
    acc(2'b10, 0, 16'hff10, ex(0, 0, 1, TGT_DEBUG, 0), 0);
    acc(2'b01, 1, 16'h3810, 0, ex(0, 1, 0, TGT_RAM, 0));
    acc(2'b01, 0, 16'h1000, 0, ex(1, 0, 0, TGT_NONE, 0));
    pwe <= 1'b1;
    pwd <= 8'hf3;
    @(posedge clk);
    pwe <= 1'b0;
    acc(2'b01, 0, 16'h8004, 0, ex(0, 0, 0, TGT_FLASH, 18'h0c004));
    chk(prd, 8'h03);
    ws <= 4'h0;
    axi(1, AXI_PAGE, 8'h05, 0);
    ws <= 4'hf;
    chk(prd, 8'h03);
    axi(1, AXI_DIRECT, 8'h80, 0);
    axi(1, AXI_DIRECT, 8'h33, 0);
    axi(0, AXI_DIRECT, 8'h00, {RESP_OKAY, 24'h0, 8'h80});
    chk(dpo, 8'h80);
    axi(0, AXI_MODE, 8'h00, {RESP_OKAY, 30'h0, 2'b11});
    axi(1, 12'hffc, 8'h11, {RESP_SLVERR, 32'h0});
    axi(0, 12'hffc, 8'h00, {RESP_SLVERR, 32'h0});
    sec <= 1'b1;
    axi(0, AXI_SECURITY, 8'h00, {RESP_OKAY, 31'h0, 1'b1});
    acc(2'b10, 0, 16'h8000, 0, 0);
    acc(2'b01, 1, 16'h8000, 0, 0);
    acc(2'b01, 0, 16'h8000, 0, ex(0, 0, 0, TGT_FLASH, 18'h0c000));
    sec <= 1'b0;
    mode <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({dent, nsc}, 2'b10);
    @(posedge clk);
    #1;
    chk({dent, prd, expq.size()}, {1'b0, PAGE_RST, 32'h0});
    wrap_up;
  end
endmodule // test_memory_map_paging_control
